// File: dtsd_pkg.sv
// shared constants, types and helpers for the fan-start step delay block
`default_nettype none

package dtsd_pkg;

	// ********************************************************************
	// register map (byte addresses) and reset values
	// ********************************************************************
	localparam logic [3:0]  DTSD_OFS_CTRL1 = 4'h0; // enables and remote b msb
	localparam logic [3:0]  DTSD_OFS_CTRL2 = 4'h4; // step delay codes
	localparam logic [3:0]  DTSD_OFS_LOCK  = 4'h8; // global lock, write once
	localparam logic [3:0]  DTSD_OFS_STAT  = 4'hc; // permits and lock, read only
	localparam logic [7:0]  DTSD_RST_CTRL1 = 8'h00;
	localparam logic [7:0]  DTSD_RST_CTRL2 = 8'h00;
	localparam logic        DTSD_RST_LOCK  = 1'b0;

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int DTSD_CTRL1_RB_MSB = 0;
	localparam int DTSD_CTRL1_EN_A   = 5;
	localparam int DTSD_CTRL1_EN_L   = 6;
	localparam int DTSD_CTRL1_EN_B   = 7;
	localparam int DTSD_CTRL2_A_LO   = 0;
	localparam int DTSD_CTRL2_L_LO   = 3;
	localparam int DTSD_CTRL2_B_LO   = 6;
	localparam int DTSD_LOCK_BIT     = 0;
	localparam int DTSD_STAT_DOWN_LO = 0;
	localparam int DTSD_STAT_UP_LO   = 3;
	localparam int DTSD_STAT_LOCK    = 6;

	// ********************************************************************
	// timing: monitoring cycle length and step delay bases
	// ********************************************************************
	localparam int          DTSD_CLK_MHZ       = 200;
	localparam int          DTSD_MON_CYCLE_MS  = 125;
	localparam int          DTSD_MON_CYCLE_CLK = DTSD_MON_CYCLE_MS * DTSD_CLK_MHZ * 1000;
	localparam int          DTSD_PRESC_W       = 25;
	localparam int          DTSD_CNT_W         = 12;
	localparam logic [11:0] DTSD_DOWN_BASE     = 12'h008;
	localparam logic [11:0] DTSD_UP_BASE       = 12'h010;
	localparam logic [11:0] DTSD_CNT_RST       = 12'h000;
	localparam logic        DTSD_WAIT_RST      = 1'b1;

	// ********************************************************************
	// types
	// ********************************************************************
	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} dtsd_avs_req_t;

	typedef struct packed {
		logic [7:0]              ctrl1;
		logic [7:0]              ctrl2;
		logic                    lock;
		logic                    waitreq;
		logic [31:0]             rdata;
		logic [DTSD_PRESC_W-1:0] presc;
		logic                    tick;
	} dtsd_top_state_t;

	typedef struct packed {
		logic [DTSD_CNT_W-1:0] cnt;
		logic                  down_ok;
		logic                  up_ok;
	} dtsd_timer_state_t;

	// monitoring cycles between downward steps for a code
	function automatic logic [11:0] dtsd_down_cycles(input logic [2:0] code);
		dtsd_down_cycles = DTSD_DOWN_BASE << code;
	endfunction

	// monitoring cycles between upward steps, always twice the downward
	function automatic logic [11:0] dtsd_up_cycles(input logic [2:0] code);
		dtsd_up_cycles = DTSD_UP_BASE << code;
	endfunction

endpackage

`default_nettype wire

// File: dtsd_timer.sv
// per-channel step delay timer counting monitoring cycles since last step
`default_nettype none

module dtsd_timer (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tick,
	input  wire logic       enable,
	input  wire logic [2:0] code,
	input  wire logic       adj_done,
	output logic            down_ok,
	output logic            up_ok
);
	import dtsd_pkg::*;

	dtsd_timer_state_t st_ff;
	dtsd_timer_state_t nxt_st;
	logic [11:0]       down_th;
	logic [11:0]       up_th;

	// ********************************************************************
	// counter and permits
	// ********************************************************************
	// count saturates at the upward limit so it never wraps
	always_comb begin
		down_th = dtsd_down_cycles(code);
		up_th   = dtsd_up_cycles(code);
		nxt_st  = st_ff;
		if (!enable || adj_done) begin
			nxt_st.cnt = DTSD_CNT_RST;
		end else if (tick && (st_ff.cnt < up_th)) begin
			nxt_st.cnt = st_ff.cnt + 12'h001;
		end
		nxt_st.down_ok = enable && !adj_done && (nxt_st.cnt >= down_th);
		nxt_st.up_ok   = enable && !adj_done && (nxt_st.cnt >= up_th);
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{cnt: DTSD_CNT_RST, down_ok: 1'b0, up_ok: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign down_ok = st_ff.down_ok;
	assign up_ok   = st_ff.up_ok;

	// ********************************************************************
	// checks
	// ********************************************************************
	a_down_at_code: assert property (@(posedge clk) disable iff (rst)
		($rose(st_ff.down_ok) && $past(code) == $past(code, 2))
		|-> (st_ff.cnt == dtsd_down_cycles($past(code))))
		else $error("down permit at wrong count");
	a_up_twice_down: assert property (@(posedge clk) disable iff (rst)
		st_ff.up_ok |-> (st_ff.down_ok && st_ff.cnt >= 12'h010))
		else $error("up permit before twice the down delay");
	a_disabled_no_permit: assert property (@(posedge clk) disable iff (rst)
		!enable |=> (!st_ff.down_ok && !st_ff.up_ok && st_ff.cnt == 12'h000))
		else $error("permit while channel disabled");
	a_step_restarts: assert property (@(posedge clk) disable iff (rst)
		(adj_done && enable) |=> (!st_ff.down_ok ##1 !st_ff.down_ok))
		else $error("permit too soon after a step");

endmodule

`default_nettype wire

// File: dtsd_top.sv
// register bank and step delay pacing for dynamic fan-start temperature control
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`default_nettype none

module dtsd_top #(
	parameter int TICK_CYCLES = dtsd_pkg::DTSD_MON_CYCLE_CLK
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire dtsd_pkg::dtsd_avs_req_t avs_req,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	input  wire logic [2:0]              adj_done,
	output logic [2:0]                   remote_a_step_delay_code,
	output logic [2:0]                   local_step_delay_code,
	output logic [2:0]                   remote_b_step_delay_code,
	output logic                         remote_a_dynamic_enable,
	output logic                         local_dynamic_enable,
	output logic                         remote_b_dynamic_enable,
	output logic [2:0]                   down_ok,
	output logic [2:0]                   up_ok,
	output logic                         lock_active
);
	import dtsd_pkg::*;

	dtsd_top_state_t st_ff;
	dtsd_top_state_t nxt_st;
	logic            acc_now;
	logic [2:0]      chan_code [3];
	logic [2:0]      chan_en;
	logic [2:0]      down_ok_w;
	logic [2:0]      up_ok_w;

	// ********************************************************************
	// bus slave, registers and monitoring cycle prescaler
	// ********************************************************************
	// one wait state: the answer is prepared, then waitrequest drops for one
	// cycle; the write lands on that same edge, so lock is checked late
	always_comb begin
		nxt_st  = st_ff;
		acc_now = !st_ff.waitreq && (avs_req.read || avs_req.write);
		if (!st_ff.waitreq) begin
			nxt_st.waitreq = 1'b1;
		end else if (avs_req.read || avs_req.write) begin
			nxt_st.waitreq = 1'b0;
			if (avs_req.address == DTSD_OFS_CTRL1) begin
				nxt_st.rdata = {24'h000000, st_ff.ctrl1};
			end else if (avs_req.address == DTSD_OFS_CTRL2) begin
				nxt_st.rdata = {24'h000000, st_ff.ctrl2};
			end else if (avs_req.address == DTSD_OFS_LOCK) begin
				nxt_st.rdata = {31'h00000000, st_ff.lock};
			end else if (avs_req.address == DTSD_OFS_STAT) begin
				nxt_st.rdata = {25'h0000000, st_ff.lock, up_ok_w, down_ok_w};
			end else begin
				nxt_st.rdata = 32'h00000000; // unmapped reads as zero
			end
		end
		// writes take effect only on the edge that ends the wait
		if (acc_now && avs_req.write && avs_req.byteenable[0]) begin
			if (avs_req.address == DTSD_OFS_CTRL1 && !st_ff.lock) begin
				nxt_st.ctrl1 = avs_req.writedata[7:0];
			end else if (avs_req.address == DTSD_OFS_CTRL2 && !st_ff.lock) begin
				nxt_st.ctrl2 = avs_req.writedata[7:0];
			end else if (avs_req.address == DTSD_OFS_LOCK) begin
				nxt_st.lock = st_ff.lock | avs_req.writedata[DTSD_LOCK_BIT];
			end
		end
		// prescaler: one tick per monitoring cycle
		if (st_ff.presc == DTSD_PRESC_W'(TICK_CYCLES - 1)) begin
			nxt_st.presc = '0;
			nxt_st.tick  = 1'b1;
		end else begin
			nxt_st.presc = st_ff.presc + DTSD_PRESC_W'(1);
			nxt_st.tick  = 1'b0;
		end
	end

	// state register; lock only clears on the power-on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{ctrl1: DTSD_RST_CTRL1, ctrl2: DTSD_RST_CTRL2, lock: DTSD_RST_LOCK,
				waitreq: DTSD_WAIT_RST, rdata: 32'h00000000, presc: '0, tick: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ********************************************************************
	// channel codes, enables and timers
	// ********************************************************************
	// channel order: 0 remote a, 1 local, 2 remote b
	assign chan_code[0] = st_ff.ctrl2[DTSD_CTRL2_A_LO +: 3];
	assign chan_code[1] = st_ff.ctrl2[DTSD_CTRL2_L_LO +: 3];
	assign chan_code[2] = {st_ff.ctrl1[DTSD_CTRL1_RB_MSB], st_ff.ctrl2[DTSD_CTRL2_B_LO +: 2]};
	assign chan_en      = {st_ff.ctrl1[DTSD_CTRL1_EN_B], st_ff.ctrl1[DTSD_CTRL1_EN_L],
		st_ff.ctrl1[DTSD_CTRL1_EN_A]};

	// one timer per channel, all paced by the shared tick
	for (genvar i = 0; i < 3; i++) begin : g_chan
		dtsd_timer u_timer (
			.clk      (clk),
			.rst      (rst),
			.tick     (st_ff.tick),
			.enable   (chan_en[i]),
			.code     (chan_code[i]),
			.adj_done (adj_done[i]),
			.down_ok  (down_ok_w[i]),
			.up_ok    (up_ok_w[i])
		);
	end

	// ********************************************************************
	// outputs, all from flip-flops
	// ********************************************************************
	assign avs_readdata             = st_ff.rdata;
	assign avs_waitrequest          = st_ff.waitreq;
	assign remote_a_step_delay_code = chan_code[0];
	assign local_step_delay_code    = chan_code[1];
	assign remote_b_step_delay_code = chan_code[2];
	assign remote_a_dynamic_enable  = chan_en[0];
	assign local_dynamic_enable     = chan_en[1];
	assign remote_b_dynamic_enable  = chan_en[2];
	assign down_ok                  = down_ok_w;
	assign up_ok                    = up_ok_w;
	assign lock_active              = st_ff.lock;

	// ********************************************************************
	// checks
	// ********************************************************************
	a_bus_answers: assert property (@(posedge clk) disable iff (rst)
		(avs_req.read || avs_req.write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus request not answered in time");
	a_code_a_write: assert property (@(posedge clk) disable iff (rst)
		(acc_now && avs_req.write && avs_req.byteenable[0] && !st_ff.lock
		&& avs_req.address == DTSD_OFS_CTRL2)
		|=> (remote_a_step_delay_code == $past(avs_req.writedata[2:0])))
		else $error("remote a code not taken from bits 2:0");
	a_code_l_write: assert property (@(posedge clk) disable iff (rst)
		(acc_now && avs_req.write && avs_req.byteenable[0] && !st_ff.lock
		&& avs_req.address == DTSD_OFS_CTRL2)
		|=> (local_step_delay_code == $past(avs_req.writedata[5:3])))
		else $error("local code not taken from bits 5:3");
	a_code_b_join: assert property (@(posedge clk) disable iff (rst)
		(acc_now && avs_req.write && avs_req.byteenable[0] && !st_ff.lock
		&& avs_req.address == DTSD_OFS_CTRL2)
		|=> (remote_b_step_delay_code[1:0] == $past(avs_req.writedata[7:6])))
		else $error("remote b low bits not taken from bits 7:6");
	a_code_b_msb: assert property (@(posedge clk) disable iff (rst)
		(acc_now && avs_req.write && avs_req.byteenable[0] && !st_ff.lock
		&& avs_req.address == DTSD_OFS_CTRL1)
		|=> (remote_b_step_delay_code[2] == $past(avs_req.writedata[0])))
		else $error("remote b msb not taken from control bit 0");
	a_tick_period: assert property (@(posedge clk) disable iff (rst)
		st_ff.tick |-> ($past(st_ff.presc) == DTSD_PRESC_W'(TICK_CYCLES - 1)))
		else $error("monitoring tick off period");
	a_lock_blocks_write: assert property (@(posedge clk) disable iff (rst)
		(st_ff.lock && acc_now && avs_req.write) |=> ($stable(st_ff.ctrl2)
		&& $stable(st_ff.ctrl1)))
		else $error("locked register changed");
	a_lock_sticks: assert property (@(posedge clk) disable iff (rst)
		lock_active |=> lock_active [*2])
		else $error("lock cleared without power cycle");

endmodule

`default_nettype wire

// File: dtsd_top_tb_top.sv
// self-checking bench for the fan-start step delay register block
`default_nettype none

module dtsd_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dtsd_pkg::*;

	// ********************************************
	// clock, reset, design
	// ********************************************
	localparam int TICK = 4; // short monitoring cycle keeps the long codes affordable
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	dtsd_avs_req_t avs_req = '0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic [2:0]    adj_done = 3'b000;
	logic [2:0]    code_a, code_l, code_b, down_ok, up_ok;
	logic          en_a, en_l, en_b, lock_active;
	logic [31:0]   exp_q[$];
	logic [31:0]   seed = 32'h01fc423f;
	logic [31:0]   r;
	int            err_count = 0;
	int            n_tests = 0;
	int            cycles = 0;

	always #2.5 clk = ~clk;

	dtsd_top #(.TICK_CYCLES(TICK)) dut (
		.clk                      (clk),
		.rst                      (rst),
		.avs_req                  (avs_req),
		.avs_readdata             (avs_readdata),
		.avs_waitrequest          (avs_waitrequest),
		.adj_done                 (adj_done),
		.remote_a_step_delay_code (code_a),
		.local_step_delay_code    (code_l),
		.remote_b_step_delay_code (code_b),
		.remote_a_dynamic_enable  (en_a),
		.local_dynamic_enable     (en_l),
		.remote_b_dynamic_enable  (en_b),
		.down_ok                  (down_ok),
		.up_ok                    (up_ok),
		.lock_active              (lock_active)
	);

	// ********************************************
	// helpers
	// ********************************************
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one access held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge clk);
		avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_req <= '0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h000000, d}, 4'hf);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		bus(1'b0, a, 32'h00000000, 4'hf);
	endtask

	// restart one channel's count, then time both permits in clocks
	task automatic measure(input int ch, input int code);
		int n;
		int dn;
		dn = (8 << code) * TICK;
		n = 1;
		@(posedge clk);
		adj_done <= 3'b001 << ch;
		@(posedge clk);
		adj_done <= 3'b000;
		@(posedge clk);
		while (down_ok[ch] !== 1'b1 && n < 2 * dn + 16) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n >= dn - TICK && n <= dn + TICK + 2}, 32'h1);
		while (up_ok[ch] !== 1'b1 && n < 2 * dn + 16) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n >= 2 * dn - TICK && n <= 2 * dn + TICK + 2}, 32'h1);
		check({29'h0, down_ok & ~(3'b001 << ch)}, 32'h0);
	endtask

	// ********************************************
	// read data watcher: oldest note against bus
	// ********************************************
	always @(posedge clk) begin
		if (avs_req.read && avs_waitrequest === 1'b0) begin
			check(avs_readdata, exp_q.pop_front());
		end
	end

	// hang guard sized to the longest code run
	always @(posedge clk) begin
		cycles++;
		if (cycles > 40000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ********************************************
	// main sequence
	// ********************************************
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(DTSD_OFS_CTRL1, DTSD_RST_CTRL1);
		rd(DTSD_OFS_CTRL2, DTSD_RST_CTRL2);
		rd(DTSD_OFS_LOCK, {7'h00, DTSD_RST_LOCK});
		// random codes and enables, read back and seen at the pins
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			r = seed;
			wr(DTSD_OFS_CTRL2, r[7:0]);
			wr(DTSD_OFS_CTRL1, r[15:8]);
			rd(DTSD_OFS_CTRL2, r[7:0]);
			rd(DTSD_OFS_CTRL1, r[15:8]);
			check({29'h0, code_a}, {29'h0, r[2:0]});
			check({29'h0, code_l}, {29'h0, r[5:3]});
			check({29'h0, code_b}, {29'h0, r[8], r[7:6]});
			check({29'h0, en_b, en_l, en_a}, {29'h0, r[15:13]});
		end
		// step pacing per channel, msb of remote b from the control register
		wr(DTSD_OFS_CTRL2, 8'h01);
		wr(DTSD_OFS_CTRL1, 8'h20);
		measure(0, 1);
		wr(DTSD_OFS_CTRL2, 8'h00);
		wr(DTSD_OFS_CTRL1, 8'h40);
		measure(1, 0);
		wr(DTSD_OFS_CTRL1, 8'h81);
		measure(2, 4);
		wr(DTSD_OFS_CTRL2, 8'h07);
		wr(DTSD_OFS_CTRL1, 8'h20);
		measure(0, 7);
		// disabling drops every permit
		wr(DTSD_OFS_CTRL1, 8'h00);
		repeat (2) @(posedge clk);
		check({26'h0, up_ok, down_ok}, 32'h0);
		// ignored writes and unmapped places
		bus(1'b1, DTSD_OFS_CTRL2, 32'h000000ff, 4'he);
		wr(DTSD_OFS_STAT, 8'hff);
		wr(4'h6, 8'hff);
		rd(DTSD_OFS_CTRL2, 8'h07);
		rd(DTSD_OFS_STAT, 8'h00);
		rd(4'h2, 8'h00);
		// lock freezes both control registers until reset
		wr(DTSD_OFS_LOCK, 8'h01);
		wr(DTSD_OFS_CTRL2, 8'h5a);
		wr(DTSD_OFS_CTRL1, 8'he1);
		wr(DTSD_OFS_LOCK, 8'h00);
		rd(DTSD_OFS_CTRL2, 8'h07);
		rd(DTSD_OFS_CTRL1, 8'h00);
		rd(DTSD_OFS_LOCK, 8'h01);
		rd(DTSD_OFS_STAT, 8'h40);
		check({31'h0, lock_active}, 32'h1);
		check({29'h0, code_b}, 32'h0);
		// reset stands for the power cycle that releases the lock
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		check({31'h0, lock_active}, 32'h0);
		wr(DTSD_OFS_CTRL2, 8'h5a);
		rd(DTSD_OFS_CTRL2, 8'h5a);
		rd(DTSD_OFS_LOCK, 8'h00);
		tally_and_finish();
	end
endmodule

`default_nettype wire
